// File: src/wrq_pkg.sv
// wrq_pkg: constants for the upper schedule slots (10 to 15) of the transmit weighted round-robin scheduler
// assumes a plain register port with one-cycle strobes and read data one cycle later
package wrq_pkg;
  localparam int WRQ_ADDR_W = 4;
  localparam int WRQ_DATA_W = 32;
  localparam int WRQ_SLOT_W = 4;
  localparam int WRQ_SEL_W = 4;
  localparam int WRQ_CNT_W = 4;
  localparam int WRQ_NUM_LOCAL = 6;
  localparam int WRQ_FIRST_SLOT = 10;
  localparam logic [WRQ_ADDR_W-1:0] WRQ_OFF_WORD_TWO = 4'h8;
  localparam logic [WRQ_ADDR_W-1:0] WRQ_OFF_WORD_THREE = 4'hc;
  localparam logic [WRQ_ADDR_W-1:0] WRQ_OFF_STATUS = 4'h0;
  localparam logic [WRQ_DATA_W-1:0] WRQ_RST_WORD = 32'h0000_0000;
  localparam logic [WRQ_SLOT_W-1:0] WRQ_SLOT_ENTRY = 4'h9;
  localparam logic [WRQ_SLOT_W-1:0] WRQ_SLOT_LAST = 4'hf;
  localparam logic [WRQ_SLOT_W-1:0] WRQ_SLOT_WRAP = 4'h0;
  // bit position of each slot's selector inside the two control words
  localparam int WRQ_SEL_POS_10 = 16;
  localparam int WRQ_SEL_POS_11 = 24;
  localparam int WRQ_SEL_POS_12 = 0;
  localparam int WRQ_SEL_POS_13 = 8;
  localparam int WRQ_SEL_POS_14 = 16;
  localparam int WRQ_SEL_POS_15 = 24;
  localparam int WRQ_CNT_OFS = 4;
  typedef enum logic [1:0] {WRQ_IDLE, WRQ_SERVE} wrq_state_t;
endpackage

// File: src/wrq_slot_decode.sv
// wrq_slot_decode: registered lookup of selector and count for the active upper slot
// assumes the two control words come from flip-flops in the top module
`timescale 1ns/1ps
`default_nettype none
module wrq_slot_decode
  import wrq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control words and slot
  input wire logic [WRQ_DATA_W-1:0] word_two,
  input wire logic [WRQ_DATA_W-1:0] word_three,
  input wire logic [WRQ_SLOT_W-1:0] slot,
  // decoded fields
  output logic [WRQ_SEL_W-1:0] sel_reg,
  output logic [WRQ_CNT_W-1:0] cnt_reg
);
  logic [7:0] pair_next;

  always_comb
  begin
    case (slot)
      4'ha: pair_next = word_two[WRQ_SEL_POS_10 +: 8];
      4'hb: pair_next = word_two[WRQ_SEL_POS_11 +: 8];
      4'hc: pair_next = word_three[WRQ_SEL_POS_12 +: 8];
      4'hd: pair_next = word_three[WRQ_SEL_POS_13 +: 8];
      4'he: pair_next = word_three[WRQ_SEL_POS_14 +: 8];
      4'hf: pair_next = word_three[WRQ_SEL_POS_15 +: 8];
      default: pair_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sel_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      sel_reg <= pair_next[WRQ_SEL_W-1:0];
      cnt_reg <= pair_next[WRQ_CNT_OFS +: WRQ_CNT_W];
    end
  end
endmodule
`default_nettype wire

// File: src/wrq_sched_upper.sv
// wrq_sched_upper: serves schedule slots 10..15, taking over from slot 9 and handing back to slot 0
// assumes the lower slots drive slot_in_valid with slot 9's end; msg_done pulses once per message sent
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each slot holds a 4-bit selector naming any of the 16 transmit queues
// - slot count code n allows n+1 contiguous messages
// - after its messages, slot k (10..14) advances to slot k+1
// - after slot 15 finishes, scheduling wraps back to slot 0
// - word two: slot 10 bits 19-16/23-20, slot 11 bits 27-24/31-28
// - word three: slots 12..15 selectors at 3-0,11-8,19-16,27-24, counts above
// - slot 10 is entered once slot 9 has finished its messages
module wrq_sched_upper
  import wrq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire logic [WRQ_ADDR_W-1:0] reg_addr,
  input wire logic [WRQ_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [WRQ_DATA_W-1:0] reg_rdata,
  // hand-over from the lower slots
  input wire logic [WRQ_SLOT_W-1:0] slot_in,
  input wire logic slot_in_valid,
  output logic [WRQ_SLOT_W-1:0] slot_out,
  output logic slot_out_valid,
  // queue fetch side
  input wire logic msg_done,
  output logic active,
  output logic [WRQ_SEL_W-1:0] queue_sel,
  output logic [WRQ_SLOT_W-1:0] cur_slot
);
  import wrq_pkg::*;

  logic [WRQ_DATA_W-1:0] word_two_reg;
  logic [WRQ_DATA_W-1:0] word_three_reg;
  wrq_state_t state_reg;
  logic [WRQ_SLOT_W-1:0] slot_reg;
  logic [WRQ_CNT_W-1:0] served_reg;
  logic [WRQ_SEL_W-1:0] dec_sel;
  logic [WRQ_CNT_W-1:0] dec_cnt;
  logic fields_ok_reg;
  logic slot_end;

  // the decode is registered, so a slot's fields are valid one cycle after entry
  wrq_slot_decode u_dec (
    .clock(clock),
    .rstn(rstn),
    .word_two(word_two_reg),
    .word_three(word_three_reg),
    .slot(slot_reg),
    .sel_reg(dec_sel),
    .cnt_reg(dec_cnt)
  );

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      word_two_reg <= WRQ_RST_WORD;
      word_three_reg <= WRQ_RST_WORD;
    end
    else if (reg_wr)
    begin
      if (reg_addr == WRQ_OFF_WORD_TWO)
        word_two_reg <= reg_wdata;
      if (reg_addr == WRQ_OFF_WORD_THREE)
        word_three_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        WRQ_OFF_WORD_TWO: reg_rdata <= word_two_reg;
        WRQ_OFF_WORD_THREE: reg_rdata <= word_three_reg;
        WRQ_OFF_STATUS: reg_rdata <= {20'h0_0000, served_reg, slot_reg, 3'h0, active};
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end

  // read path: data stand for exactly one cycle after the strobe, zero otherwise
  rdata_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside a read");
  read_two_a: assert property (@(posedge clock) disable iff (!rstn)
    ($past(reg_rd) && ($past(reg_addr) == WRQ_OFF_WORD_TWO)) |->
      reg_rdata == $past(word_two_reg))
    else $error("word two read back wrong");
  read_three_a: assert property (@(posedge clock) disable iff (!rstn)
    ($past(reg_rd) && ($past(reg_addr) == WRQ_OFF_WORD_THREE)) |->
      reg_rdata == $past(word_three_reg))
    else $error("word three read back wrong");

  // last message of the slot: served count reaches the code, i.e. code+1 messages
  assign slot_end = (state_reg == WRQ_SERVE) && fields_ok_reg && msg_done && (served_reg == dec_cnt);

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_reg <= WRQ_IDLE;
      slot_reg <= WRQ_SLOT_ENTRY;
      served_reg <= '0;
      fields_ok_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        WRQ_IDLE:
        begin
          fields_ok_reg <= 1'b0;
          served_reg <= '0;
          if (slot_in_valid && slot_in == WRQ_SLOT_ENTRY)
          begin
            state_reg <= WRQ_SERVE;
            // entry always lands on slot 10, the lower part owns slot 9
            slot_reg <= WRQ_SLOT_ENTRY + 4'h1;
          end
        end
        WRQ_SERVE:
        begin
          fields_ok_reg <= 1'b1;
          if (slot_end)
          begin
            served_reg <= '0;
            fields_ok_reg <= 1'b0;
            if (slot_reg == WRQ_SLOT_LAST)
            begin
              state_reg <= WRQ_IDLE;
              slot_reg <= WRQ_SLOT_ENTRY;
            end
            else
              slot_reg <= slot_reg + 4'h1;
          end
          else if (fields_ok_reg && msg_done)
            served_reg <= served_reg + 4'h1;
        end
        default: state_reg <= WRQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      slot_out <= WRQ_SLOT_WRAP;
      slot_out_valid <= 1'b0;
      active <= 1'b0;
      queue_sel <= '0;
      cur_slot <= WRQ_SLOT_ENTRY;
    end
    else
    begin
      slot_out_valid <= slot_end && (slot_reg == WRQ_SLOT_LAST);
      slot_out <= WRQ_SLOT_WRAP;
      active <= (state_reg == WRQ_SERVE) && fields_ok_reg && !slot_end;
      queue_sel <= dec_sel;
      cur_slot <= slot_reg;
    end
  end

  wrap_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
    (slot_end && slot_reg == WRQ_SLOT_LAST) |=> slot_out_valid && slot_out == WRQ_SLOT_WRAP)
    else $error("slot 15 end did not hand back to slot 0");
  slot_advance_a: assert property (@(posedge clock) disable iff (!rstn)
    (slot_end && slot_reg != WRQ_SLOT_LAST) |=> slot_reg == $past(slot_reg) + 4'h1)
    else $error("slot did not advance by one");
  entry_slot_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_IDLE && slot_in_valid && slot_in == WRQ_SLOT_ENTRY) |=> slot_reg == 4'ha)
    else $error("slot 10 not entered after slot 9");
  count_bound_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE) |-> served_reg <= dec_cnt || !fields_ok_reg)
    else $error("served more messages than the count allows");
  upper_range_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE) |-> slot_reg >= 4'ha)
    else $error("serving slot outside 10 to 15");
  sel_follow_a: assert property (@(posedge clock) disable iff (!rstn)
    (active && cur_slot == 4'hd) |->
      queue_sel == word_three_reg[11:8] || $past(reg_wr) || $past(reg_wr, 2))
    else $error("queue select does not follow the slot field");
  word_two_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE && slot_reg == 4'ha && fields_ok_reg) |->
      dec_sel == word_two_reg[19:16] || $past(reg_wr))
    else $error("slot 10 selector not from bits 19-16");
  word_three_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE && slot_reg == 4'hc && fields_ok_reg) |->
      dec_cnt == word_three_reg[7:4] || $past(reg_wr))
    else $error("slot 12 count not from bits 7-4");
  slot_eleven_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE && slot_reg == 4'hb && fields_ok_reg) |->
      dec_cnt == word_two_reg[31:28] || $past(reg_wr))
    else $error("slot 11 count not from bits 31-28");
  slot_fifteen_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE && slot_reg == 4'hf && fields_ok_reg) |->
      dec_sel == word_three_reg[27:24] || $past(reg_wr))
    else $error("slot 15 selector not from bits 27-24");

  // sequencing: slots hold until served, then step, wrap and go idle
  wrap_only_a: assert property (@(posedge clock) disable iff (!rstn)
    slot_out_valid |-> $past(slot_end) && ($past(slot_reg) == WRQ_SLOT_LAST))
    else $error("slot 0 hand-back without slot 15 end");
  idle_return_a: assert property (@(posedge clock) disable iff (!rstn)
    (slot_end && slot_reg == WRQ_SLOT_LAST) |=> state_reg == WRQ_IDLE && slot_reg == WRQ_SLOT_ENTRY)
    else $error("scheduler not idle after slot 15");
  stay_idle_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_IDLE && !(slot_in_valid && slot_in == WRQ_SLOT_ENTRY)) |=> state_reg == WRQ_IDLE)
    else $error("upper slots started without slot 9 finishing");
  slot_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE && !slot_end) |=> slot_reg == $past(slot_reg))
    else $error("slot left before its messages were served");
  served_step_a: assert property (@(posedge clock) disable iff (!rstn)
    (state_reg == WRQ_SERVE && fields_ok_reg && msg_done && !slot_end) |=>
      served_reg == $past(served_reg) + 4'h1)
    else $error("served count did not step by one");
  active_drop_a: assert property (@(posedge clock) disable iff (!rstn)
    slot_end |=> !active)
    else $error("active stayed high across a slot change");
endmodule
`default_nettype wire

// File: testbench/wrq_fetch_model.sv
// wrq_fetch_model: stand-in for the queue fetch and transmit logic
// assumes active marks the cycles in which the scheduler counts msg_done
`timescale 1ns/1ps
`default_nettype none
module wrq_fetch_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // scheduler side
  input wire logic active,
  input wire logic [3:0] gap,
  output logic msg_done
);
  logic [3:0] wait_reg;
  // at least one idle cycle after each pulse, so the slot change lands first
  always_ff @(posedge clock)
  begin
    if (!rstn || !active)
    begin
      wait_reg <= 4'h0;
      msg_done <= 1'b0;
    end
    else if (msg_done || wait_reg < gap)
    begin
      wait_reg <= msg_done ? 4'h0 : wait_reg + 4'h1;
      msg_done <= 1'b0;
    end
    else
    begin
      wait_reg <= 4'h0;
      msg_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb.sv
// tb: self-checking bench for the upper schedule slots
// assumes the fetch model answers every active slot with msg_done pulses
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wrq_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [WRQ_ADDR_W-1:0] reg_addr = 4'h0;
  logic [WRQ_DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [WRQ_DATA_W-1:0] reg_rdata, w2, w3;
  logic [3:0] slot_in = 4'h0;
  logic slot_in_valid = 1'b0;
  logic [3:0] slot_out, queue_sel, cur_slot, exp_next, last_slot;
  logic [3:0] gap = 4'h0;
  logic slot_out_valid, msg_done, active;
  int n_errors = 0;
  int n_tests = 0;
  int seen [16];
  always #10 clock = ~clock;
  wrq_sched_upper i_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_in(slot_in), .slot_in_valid(slot_in_valid),
    .slot_out(slot_out), .slot_out_valid(slot_out_valid), .msg_done(msg_done), .active(active),
    .queue_sel(queue_sel), .cur_slot(cur_slot));
  wrq_fetch_model i_far (.clock(clock), .rstn(rstn), .active(active), .gap(gap), .msg_done(msg_done));
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // {count, selector} of a slot, worked out from the written words
  function automatic logic [7:0] fld(input logic [3:0] s);
    fld = (s < 4'hc) ? w2[16 + (s - 10) * 8 +: 8] : w3[(s - 12) * 8 +: 8];
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, e);
  endtask
  // sample a step after the edge, once the scheduler's flops have settled
  always @(posedge clock)
  begin
    #1;
    if (rstn && active)
    begin
      if (cur_slot !== last_slot)
      begin
        check("cur_slot", cur_slot, exp_next);
        exp_next = exp_next + 4'h1;
        last_slot = cur_slot;
      end
      if (msg_done)
      begin
        seen[cur_slot]++;
        check("queue_sel", queue_sel, fld(cur_slot) & 8'h0f);
      end
    end
  end
  task automatic t_regs;
    rd(WRQ_OFF_STATUS, 32'h0000_0090);
    rd(WRQ_OFF_WORD_TWO, WRQ_RST_WORD);
    rd(WRQ_OFF_WORD_THREE, WRQ_RST_WORD);
    wr(WRQ_OFF_WORD_TWO, 32'ha5c3_1234);
    wr(4'h4, 32'hffff_ffff);
    rd(WRQ_OFF_WORD_TWO, 32'ha5c3_1234);
    rd(4'h4, 32'h0);
  endtask
  task automatic run_round(input logic [31:0] a, input logic [31:0] b, input logic [3:0] g);
    int i;
    w2 = a;
    w3 = b;
    gap <= g;
    wr(WRQ_OFF_WORD_TWO, a);
    wr(WRQ_OFF_WORD_THREE, b);
    seen = '{default: 0};
    exp_next = 4'ha;
    last_slot = 4'h9;
    @(posedge clock);
    slot_in <= WRQ_SLOT_ENTRY;
    slot_in_valid <= 1'b1;
    @(posedge clock);
    slot_in_valid <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check("active", active, 1'b1);
    check("entry slot", cur_slot, 4'ha);
    i = 0;
    do
    begin
      @(posedge clock);
      #1 i++;
    end
    while (slot_out_valid !== 1'b1 && i < 2000);
    check("slot_out_valid", slot_out_valid, 1'b1);
    check("slot_out", slot_out, WRQ_SLOT_WRAP);
    check("last slot", exp_next, 4'h0);
    for (int s = 10; s < 16; s++)
      check("msg count", seen[s], (fld(4'(s)) >> 4) + 1);
    repeat (3) @(posedge clock);
    #1 check("idle slot", cur_slot, WRQ_SLOT_ENTRY);
  endtask
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_regs;
    // lower halfword must not disturb slots 10 and 11
    run_round(32'hfc03_ffff, 32'h0f30_1a25, 4'h0);
    run_round(32'h01ff_0000, 32'hf0e2_d4c6, 4'h2);
    end_sim;
  end
  initial
  begin
    #200us;
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
